// >>> pkg/fpmc_pkg.sv
package fpmc_pkg;
    // apb register byte offsets
    localparam logic [11:0] FPMC_CTRL_OFS = 12'h000;
    localparam logic [11:0] FPMC_STAT_OFS = 12'h004;
    localparam logic [11:0] FPMC_PARAM_OFS = 12'h008;
    localparam logic [11:0] FPMC_TC_OFS = 12'h00c;
    localparam logic [11:0] FPMC_LEVEL_OFS = 12'h010;
    // control field positions
    localparam int FPMC_CTRL_LOCK_BIT = 0;
    localparam int FPMC_CTRL_PRESET_BIT = 1;
    // reset values
    localparam logic FPMC_LOCK_RST = 1'b1;
    localparam logic [3:0] FPMC_ITEM_RST = 4'h0;
    localparam logic signed [7:0] FPMC_LEVEL_RST = 8'sh00;
    // parameter list
    localparam logic [3:0] FPMC_GEN_SETUP_ITEM = 4'h0;
    localparam logic [3:0] FPMC_LTC_LEVEL_ITEM = 4'h1;
    localparam logic [3:0] FPMC_VIDEO_SYNC_ITEM = 4'h2;
    localparam int FPMC_NUM_ITEMS = 8;
    // level figures in dBu
    localparam logic signed [7:0] FPMC_LEVEL_STEP = 8'sh03;
    localparam logic signed [7:0] FPMC_LEVEL_MIN = -8'sh18;
    localparam logic signed [7:0] FPMC_LEVEL_MAX = 8'sh09;
    // timing
    localparam int FPMC_CLK_MHZ = 250;
    localparam int FPMC_DEBOUNCE_US = 10;
    localparam int FPMC_DEBOUNCE_CYC = FPMC_DEBOUNCE_US * FPMC_CLK_MHZ;
    localparam int FPMC_REPEAT_MS = 100;
    localparam int FPMC_REPEAT_CYC = FPMC_REPEAT_MS * 1000 * FPMC_CLK_MHZ;

    typedef enum logic [1:0] {
        FPMC_SHOW_TC = 2'b00,
        FPMC_SHOW_NAME = 2'b01,
        FPMC_SHOW_VALUE = 2'b10
    } fpmc_mode_t;

    typedef struct packed {
        logic setKey;
        logic downKey;
        logic upKey;
        logic runKey;
        logic clockRefKey;
        logic posRefKey;
        logic frameRateKey;
    } fpmc_keys_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } fpmc_apb_req_t;
endpackage

// >>> verilog/fpmc_front_panel.sv
`timescale 1ns/10ps
module fpmc_front_panel #(
    parameter int DEBOUNCE_CYC = fpmc_pkg::FPMC_DEBOUNCE_CYC,
    parameter int REPEAT_CYC = fpmc_pkg::FPMC_REPEAT_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // apb slave
    input wire fpmc_pkg::fpmc_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // front panel keys, high while pressed
    input wire fpmc_pkg::fpmc_keys_t keys,
    // display, lamps, generator run and counter clear
    output logic [1:0] displayMode,
    output logic [3:0] shownItem,
    output logic signed [7:0] shownLevel,
    output logic [1:0] cursorField,
    output logic lockoutLamp,
    output logic generatorRun,
    output logic counterClearPulse
);
    import fpmc_pkg::*;

    localparam int NK = 7;
    localparam int DBW = $clog2(DEBOUNCE_CYC + 1);
    localparam int RPW = $clog2(REPEAT_CYC + 1);

    function automatic logic [3:0] stepItem(input logic [3:0] it, input logic up);
        logic [3:0] n;
        n = 4'h0;
        if (up) begin
            n = (it == 4'(FPMC_NUM_ITEMS - 1)) ? 4'h0 : it + 4'h1;
        end else begin
            n = (it == 4'h0) ? 4'(FPMC_NUM_ITEMS - 1) : it - 4'h1;
        end
        return n;
    endfunction

    // debounce: a key state is accepted after it has been stable for DEBOUNCE_CYC
    logic [NK-1:0] rawKeys;
    logic [NK-1:0] stable_q;
    logic [NK-1:0] prev_q;
    logic [DBW-1:0] dbCnt_q [NK];
    assign rawKeys = keys;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dbCnt_q <= '{default: '0};
            stable_q <= '0;
        end else begin
            for (int k = 0; k < NK; k++) begin
                if (rawKeys[k] == stable_q[k]) begin
                    dbCnt_q[k] <= '0;
                end else if (dbCnt_q[k] == DBW'(DEBOUNCE_CYC - 1)) begin
                    dbCnt_q[k] <= '0;
                    stable_q[k] <= rawKeys[k];
                end else begin
                    dbCnt_q[k] <= dbCnt_q[k] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q <= '0;
        end else begin
            prev_q <= stable_q;
        end
    end

    wire [NK-1:0] pressEdge = stable_q & ~prev_q;
    // bit order follows struct: set down up run clk pos frame
    wire setPress = pressEdge[6];
    wire downHeld = stable_q[5];
    wire upHeld = stable_q[4];
    wire runPress = pressEdge[3];
    wire exitCombo = &stable_q[2:0];

    // auto-repeat on held down/up
    logic [RPW-1:0] rptCnt_q;
    wire singleHeld = downHeld ^ upHeld;
    wire rptTick = singleHeld && (rptCnt_q == RPW'(REPEAT_CYC - 1));
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rptCnt_q <= '0;
        end else if (!singleHeld || rptTick) begin
            rptCnt_q <= '0;
        end else begin
            rptCnt_q <= rptCnt_q + 1'b1;
        end
    end

    logic lockout_q;
    logic lockout_d;
    fpmc_mode_t mode_q;
    fpmc_mode_t mode_d;
    logic [3:0] item_q;
    logic [3:0] item_d;
    logic signed [7:0] level_q;
    logic signed [7:0] level_d;
    logic signed [7:0] edit_q;
    logic signed [7:0] edit_d;
    logic [1:0] field_q;
    logic [1:0] field_d;
    logic run_q;
    logic run_d;
    logic clr_q;
    logic clr_d;
    logic preset_q;

    wire stepDn = (pressEdge[5] && !upHeld) || (rptTick && downHeld);
    wire stepUp = (pressEdge[4] && !downHeld) || (rptTick && upHeld);
    wire tabPress = (pressEdge[5] && upHeld) || (pressEdge[4] && downHeld);
    wire active = !lockout_q;
    wire editTc = (mode_q == FPMC_SHOW_VALUE) && (item_q == FPMC_GEN_SETUP_ITEM);
    wire editLvl = item_q == FPMC_LTC_LEVEL_ITEM;
    wire signed [7:0] lvlUp = (edit_q >= FPMC_LEVEL_MAX - FPMC_LEVEL_STEP) ?
        FPMC_LEVEL_MAX : edit_q + FPMC_LEVEL_STEP;
    wire signed [7:0] lvlDn = (edit_q <= FPMC_LEVEL_MIN + FPMC_LEVEL_STEP) ?
        FPMC_LEVEL_MIN : edit_q - FPMC_LEVEL_STEP;

    // apb decode
    wire apbWr = apbReq.psel && apbReq.penable && apbReq.pwrite;
    wire apbRd = apbReq.psel && !apbReq.pwrite;
    wire wrCtrl = apbWr && (apbReq.paddr == FPMC_CTRL_OFS);
    wire [31:0] rdMux =
        (apbReq.paddr == FPMC_CTRL_OFS) ? {30'h0, preset_q, lockout_q} :
        (apbReq.paddr == FPMC_STAT_OFS) ? {26'h0, field_q, run_q, 1'b0, mode_q} :
        (apbReq.paddr == FPMC_PARAM_OFS) ? {28'h0, item_q} :
        (apbReq.paddr == FPMC_LEVEL_OFS) ? {{24{level_q[7]}}, level_q} : 32'h0;
    wire mapped = (apbReq.paddr == FPMC_CTRL_OFS) || (apbReq.paddr == FPMC_STAT_OFS) ||
        (apbReq.paddr == FPMC_PARAM_OFS) || (apbReq.paddr == FPMC_LEVEL_OFS);

    always_comb begin
        lockout_d = lockout_q;
        mode_d = mode_q;
        item_d = item_q;
        level_d = level_q;
        edit_d = edit_q;
        field_d = field_q;
        run_d = run_q;
        clr_d = 1'b0;
        if (lockout_q && exitCombo) begin
            lockout_d = 1'b0;
        end else if (wrCtrl) begin
            lockout_d = apbReq.pwdata[FPMC_CTRL_LOCK_BIT];
        end
        if (active) begin
            unique case (mode_q)
                FPMC_SHOW_TC: begin
                    if (setPress) begin
                        mode_d = FPMC_SHOW_NAME;
                    end else if (runPress && preset_q) begin
                        run_d = !run_q;
                    end else if (runPress) begin
                        clr_d = 1'b1;
                    end
                end
                FPMC_SHOW_NAME: begin
                    if (setPress) begin
                        mode_d = FPMC_SHOW_VALUE;
                        edit_d = level_q;
                        field_d = 2'h0;
                    end else if (runPress) begin
                        mode_d = FPMC_SHOW_TC;
                    end else if (stepUp) begin
                        item_d = stepItem(item_q, 1'b1);
                    end else if (stepDn) begin
                        item_d = stepItem(item_q, 1'b0);
                    end
                end
                FPMC_SHOW_VALUE: begin
                    if (setPress) begin
                        mode_d = FPMC_SHOW_TC;
                        if (editLvl) begin
                            level_d = edit_q;
                        end
                    end else if (runPress) begin
                        mode_d = FPMC_SHOW_TC;
                    end else if (tabPress && editTc) begin
                        field_d = field_q + 2'h1;
                    end else if (stepUp && editLvl) begin
                        edit_d = lvlUp;
                    end else if (stepDn && editLvl) begin
                        edit_d = lvlDn;
                    end
                end
                default: mode_d = FPMC_SHOW_TC;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lockout_q <= FPMC_LOCK_RST;
            preset_q <= 1'b0;
            mode_q <= FPMC_SHOW_TC;
            item_q <= FPMC_ITEM_RST;
            level_q <= FPMC_LEVEL_RST;
            edit_q <= FPMC_LEVEL_RST;
            field_q <= 2'h0;
            run_q <= 1'b0;
            clr_q <= 1'b0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            lockout_q <= lockout_d;
            if (wrCtrl) begin
                preset_q <= apbReq.pwdata[FPMC_CTRL_PRESET_BIT];
            end
            mode_q <= mode_d;
            item_q <= item_d;
            level_q <= level_d;
            edit_q <= edit_d;
            field_q <= field_d;
            run_q <= run_d;
            clr_q <= clr_d;
            pready <= apbReq.psel && !apbReq.penable;
            pslverr <= apbReq.psel && !apbReq.penable && !mapped;
            if (apbRd && !apbReq.penable) begin
                prdata <= rdMux;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            displayMode <= 2'b00;
            shownItem <= 4'h0;
            shownLevel <= 8'sh00;
            cursorField <= 2'h0;
            lockoutLamp <= FPMC_LOCK_RST;
        end else begin
            displayMode <= mode_d;
            shownItem <= item_d;
            shownLevel <= edit_d;
            cursorField <= field_d;
            lockoutLamp <= lockout_d;
        end
    end
    assign generatorRun = run_q;
    assign counterClearPulse = clr_q;

    a_lockout_lamp: assert property (@(posedge sys_clk) disable iff (!reset_n)
        lockoutLamp == lockout_q) else $error("lamp not tracking lockout");
    a_lockout_ignore: assert property (@(posedge sys_clk) disable iff (!reset_n)
        lockout_q && setPress |=> $stable(mode_q)) else $error("key acted in lockout");
    a_exit_combo: assert property (@(posedge sys_clk) disable iff (!reset_n)
        lockout_q && exitCombo |=> !lockout_q) else $error("exit combo ignored");
    a_set_from_tc: assert property (@(posedge sys_clk) disable iff (!reset_n)
        active && mode_q == FPMC_SHOW_TC && setPress |=> mode_q == FPMC_SHOW_NAME)
        else $error("set did not show names");
    a_set_commit: assert property (@(posedge sys_clk) disable iff (!reset_n)
        active && mode_q == FPMC_SHOW_VALUE && setPress && editLvl
        |=> level_q == $past(edit_q) && mode_q == FPMC_SHOW_TC)
        else $error("commit failed");
    a_cancel_keeps: assert property (@(posedge sys_clk) disable iff (!reset_n)
        active && mode_q == FPMC_SHOW_VALUE && runPress && !setPress
        |=> $stable(level_q) && mode_q == FPMC_SHOW_TC) else $error("cancel wrote");
    a_level_range: assert property (@(posedge sys_clk) disable iff (!reset_n)
        edit_q >= FPMC_LEVEL_MIN && edit_q <= FPMC_LEVEL_MAX)
        else $error("level out of range");
    a_clear_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
        counterClearPulse |-> $past(mode_q) == FPMC_SHOW_TC && !$past(preset_q))
        else $error("clear outside time code");
    a_run_toggle: assert property (@(posedge sys_clk) disable iff (!reset_n)
        active && mode_q == FPMC_SHOW_TC && preset_q && runPress && !setPress
        |=> run_q != $past(run_q)) else $error("run did not toggle");
    a_tab_field: assert property (@(posedge sys_clk) disable iff (!reset_n)
        active && editTc && tabPress && !setPress && !runPress
        |=> field_q == $past(field_q) + 2'h1) else $error("tab did not advance");
    a_name_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
        active && mode_q == FPMC_SHOW_NAME && (stepUp || stepDn) && !setPress && !runPress
        |=> item_q != $past(item_q)) else $error("name did not step");
    c_commit: cover property (@(posedge sys_clk) mode_q == FPMC_SHOW_VALUE && setPress);
    c_unlock: cover property (@(posedge sys_clk) lockout_q && exitCombo);
    c_repeat: cover property (@(posedge sys_clk) rptTick);
    c_tab: cover property (@(posedge sys_clk) active && editTc && tabPress);
    c_cancel: cover property (@(posedge sys_clk) mode_q == FPMC_SHOW_VALUE && runPress);
endmodule

// >>> testbench/fpmc_panel_model.sv
`timescale 1ns/10ps
module fpmc_panel_model (
    // clock
    input wire logic sys_clk,
    // switches toward the device, high while pressed
    output fpmc_pkg::fpmc_keys_t keys
);
    import fpmc_pkg::*;

    // released switches sit at the pulled-down idle level
    initial begin
        keys = '0;
    end

    // hold a combination for a while, let go, give the device time to react
    task automatic press(input fpmc_keys_t mask, input int hold);
        @(posedge sys_clk);
        keys <= mask;
        repeat (hold) @(posedge sys_clk);
        keys <= '0;
        repeat (12) @(posedge sys_clk);
    endtask
endmodule

// >>> testbench/tb_front_panel_menu_controller.sv
`timescale 1ns/10ps
module tb_front_panel_menu_controller;
    import fpmc_pkg::*;
    localparam int DEB = 4;
    localparam int REP = 20;
    localparam logic [6:0] kSet = 7'h40;
    localparam logic [6:0] kDown = 7'h20;
    localparam logic [6:0] kUp = 7'h10;
    localparam logic [6:0] kRun = 7'h08;
    localparam logic [6:0] kExit = 7'h07;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    fpmc_apb_req_t apbReq = '0;
    fpmc_keys_t keys;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] displayMode;
    logic [3:0] shownItem;
    logic signed [7:0] shownLevel;
    logic [1:0] cursorField;
    logic lockoutLamp;
    logic generatorRun;
    logic counterClearPulse;
    int error_cnt = 0;
    int checked = 0;
    int clrCnt = 0;
    int seedDummy;
    int n;
    logic [31:0] rd;
    logic err;
    logic signed [7:0] lvl;

    always #2 sys_clk = ~sys_clk;

    always @(posedge sys_clk) if (counterClearPulse === 1'b1) clrCnt <= clrCnt + 1;

    fpmc_front_panel #(.DEBOUNCE_CYC(DEB), .REPEAT_CYC(REP)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .apbReq(apbReq), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .keys(keys), .displayMode(displayMode),
        .shownItem(shownItem), .shownLevel(shownLevel), .cursorField(cursorField),
        .lockoutLamp(lockoutLamp), .generatorRun(generatorRun),
        .counterClearPulse(counterClearPulse)
    );

    fpmc_panel_model u_panel (.sys_clk(sys_clk), .keys(keys));

    function automatic logic signed [7:0] stepLevel(input logic signed [7:0] v, input logic up);
        logic signed [7:0] t;
        t = up ? v + FPMC_LEVEL_STEP : v - FPMC_LEVEL_STEP;
        if (t > FPMC_LEVEL_MAX) t = FPMC_LEVEL_MAX;
        if (t < FPMC_LEVEL_MIN) t = FPMC_LEVEL_MIN;
        return t;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int w;
        @(posedge sys_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        w = 0;
        do begin
            @(posedge sys_clk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        if (w >= 50) error_cnt++;
        rd = prdata;
        err = pslverr;
        apbReq <= '0;
    endtask

    task automatic key(input logic [6:0] m);
        u_panel.press(fpmc_keys_t'(m), 8);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        summarize();
    end

    initial begin
        seedDummy = $urandom(5);
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check(32'(lockoutLamp), 32'h1);
        key(kSet);
        check(32'(displayMode), 32'(FPMC_SHOW_TC));
        key(kExit);
        check(32'(lockoutLamp), 32'h0);
        // generator preset mode: run toggles, no clear
        apb(1'b1, FPMC_CTRL_OFS, 32'h2);
        key(kRun);
        check(32'(generatorRun), 32'h1);
        key(kRun);
        check(32'(generatorRun), 32'h0);
        check(32'(clrCnt), 32'h0);
        apb(1'b1, FPMC_CTRL_OFS, 32'h0);
        key(kRun);
        check(32'(clrCnt), 32'h1);
        key(kSet);
        check(32'(displayMode), 32'(FPMC_SHOW_NAME));
        check(32'(shownItem), 32'(FPMC_GEN_SETUP_ITEM));
        key(kSet);
        key(kDown | kUp);
        check(32'(cursorField), 32'h1);
        key(kDown | kUp);
        check(32'(cursorField), 32'h2);
        apb(1'b0, FPMC_STAT_OFS, 32'h0);
        // status: field in bits 5:4, run in bit 3, mode in bits 1:0
        check(rd, {26'h0, 2'h2, 1'b0, 1'b0, 2'(FPMC_SHOW_VALUE)});
        check({31'h0, err}, 32'h0);
        key(kRun);
        check(32'(displayMode), 32'(FPMC_SHOW_TC));
        key(kSet);
        key(kDown);
        check(32'(shownItem), 32'(FPMC_NUM_ITEMS - 1));
        key(kUp);
        key(kUp);
        check(32'(shownItem), 32'(FPMC_LTC_LEVEL_ITEM));
        apb(1'b0, FPMC_PARAM_OFS, 32'h0);
        check(rd, 32'(FPMC_LTC_LEVEL_ITEM));
        key(kSet);
        check(32'(displayMode), 32'(FPMC_SHOW_VALUE));
        lvl = FPMC_LEVEL_RST;
        check(32'(shownLevel), 32'(lvl));
        repeat (5) begin
            key(kUp);
            lvl = stepLevel(lvl, 1'b1);
            check(32'(shownLevel), 32'(lvl));
        end
        n = $urandom_range(14, 4);
        repeat (n) begin
            key(kDown);
            lvl = stepLevel(lvl, 1'b0);
        end
        check(32'(shownLevel), 32'(lvl));
        apb(1'b0, FPMC_LEVEL_OFS, 32'h0);
        check(32'(rd[7:0]), 32'(FPMC_LEVEL_RST));
        key(kSet);
        check(32'(displayMode), 32'(FPMC_SHOW_TC));
        apb(1'b0, FPMC_LEVEL_OFS, 32'h0);
        check(32'(rd[7:0]), 32'(lvl[7:0]));
        key(kSet);
        check(32'(shownItem), 32'(FPMC_LTC_LEVEL_ITEM));
        key(kSet);
        key(kUp);
        check(32'(shownLevel), 32'(stepLevel(lvl, 1'b1)));
        key(kRun);
        apb(1'b0, FPMC_LEVEL_OFS, 32'h0);
        check(32'(rd[7:0]), 32'(lvl[7:0]));
        key(kSet);
        u_panel.press(fpmc_keys_t'(kUp), 8 + 3 * REP);
        // one step on the press edge, then one per repeat period: three in the hold
        check(32'(shownItem), 32'(FPMC_LTC_LEVEL_ITEM + 4));
        key(kRun);
        apb(1'b1, FPMC_CTRL_OFS, 32'h1);
        repeat (2) @(posedge sys_clk);
        check(32'(lockoutLamp), 32'h1);
        key(kSet);
        check(32'(displayMode), 32'(FPMC_SHOW_TC));
        key(kExit);
        check(32'(lockoutLamp), 32'h0);
        apb(1'b0, FPMC_TC_OFS, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        summarize();
    end
endmodule
